/* src/pgic_pkg.sv */
// Shared constants and state types for the general purpose port block.
// Assumes one logic clock and an active-low asynchronous reset.
package pgic_pkg;

    // ------------------------------------------------------------
    // Port counts and indices
    // ------------------------------------------------------------
    localparam int NUM_PORTS = 3;
    localparam int NUM_IRQ_PORTS = 2;
    localparam int IDX_ONE = 0;
    localparam int IDX_TWO = 1;
    localparam int IDX_THREE = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [2:0] PORT_IN_RST = 3'h0;
    localparam logic [2:0] PIN_SYNC_RST = 3'h7;
    localparam logic HOST_INT_N_RST = 1'h1;
    localparam logic CONV_EN_RST = 1'h0;
    localparam logic STANDBY_RST = 1'h0;
    localparam logic ADC_START_RST = 1'h0;

    // ------------------------------------------------------------
    // Field encodings
    // ------------------------------------------------------------
    localparam logic DIR_OUTPUT = 1'h1;
    localparam logic LVL_FALL_HI = 1'h1;
    localparam logic P3_EDGE_RISE = 1'h1;
    localparam logic OD_DRIVE_VALUE = 1'h0;

    // Interrupt latch sequence of one port.
    typedef enum logic [1:0] {
        PGIC_IRQ_IDLE,
        PGIC_IRQ_ASSERTED,
        PGIC_IRQ_CLEARABLE
    } pgic_irq_state_t;

endpackage

/* src/pgic_edge_latch.sv */
// Edge-triggered interrupt latch for one general purpose port.
// Assumes its pin input is already synchronised to mclk.
`timescale 1ns/100ps

module pgic_edge_latch (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Detected events
    input wire logic edge_seen,
    input wire logic read_done,
    input wire logic force_clear,
    // Request to the interrupt gate
    output logic irq_req
);

    typedef struct packed {
        pgic_pkg::pgic_irq_state_t st;
    } pgic_latch_state_t;

    pgic_latch_state_t s_r;
    pgic_latch_state_t s_nxt;

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        case (s_r.st)
            pgic_pkg::PGIC_IRQ_IDLE: begin
                if (edge_seen) begin
                    s_nxt.st = pgic_pkg::PGIC_IRQ_ASSERTED;
                end
            end
            pgic_pkg::PGIC_IRQ_ASSERTED: begin
                // A read before the second edge leaves the request standing.
                if (edge_seen) begin
                    s_nxt.st = pgic_pkg::PGIC_IRQ_CLEARABLE;
                end
            end
            pgic_pkg::PGIC_IRQ_CLEARABLE: begin
                // Further edges change nothing until the host reads.
                if (read_done) begin
                    s_nxt.st = pgic_pkg::PGIC_IRQ_IDLE;
                end
            end
            default: begin
                s_nxt.st = pgic_pkg::PGIC_IRQ_IDLE;
            end
        endcase
        if (force_clear) begin
            s_nxt.st = pgic_pkg::PGIC_IRQ_IDLE;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_r.st <= pgic_pkg::PGIC_IRQ_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign irq_req = (s_r.st != pgic_pkg::PGIC_IRQ_IDLE);

endmodule

/* src/pgic_top.sv */
// Three open-drain general purpose ports with interrupt, converter
// control and conversion trigger functions.
// Assumes configuration inputs come from the register file on mclk and
// that the pins arrive asynchronously from outside the chip.
`timescale 1ns/100ps

// What this block does
// - Three open-drain ports, each set by the host as input or output.
// - An output port drives the last host-written LO or HI level.
// - Ports one and two in interrupt mode raise a request on a transition.
// - Each port request is masked before reaching the host interrupt line.
// - Port one steers converter A and standby; port two steers converter B.
// - Port three starts a conversion when its trigger bit is set, unless it is set as an output.
// - In converter-enable mode the pin level turns the converter on, polarity chosen.
// - In standby mode port one's level requests standby of both, polarity chosen.
// - The host chooses rising or falling edge for interrupt mode.
// - Each port input passes two flip-flop stages before interrupt logic.
// - The interrupt line goes low after the first selected edge.
// - Short of a release or mask change, the line returns high only after a completed serial read.
// - Clearing needs two edges before the read; one edge is not enough.
// - Without reads, further edges leave the interrupt line unchanged.
// - Undervoltage lockout or switching ports to outputs releases the line.
// - A converter runs only when register and port both request it.
// - Standby only when register and port both request it.
module pgic_top (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Port pins, open drain
    input wire logic [2:0] pin_in,
    output logic [2:0] pin_out,
    output logic [2:0] pin_oe,
    // Port direction and output level
    input wire logic [2:0] port_dir_out,
    input wire logic [2:0] port_out_level,
    // Edge and level selection for ports one and two
    input wire logic [1:0] port_lvl_sel,
    // Input modes
    input wire logic [1:0] port_int_en,
    input wire logic port_one_conv_a_en,
    input wire logic port_one_standby_en,
    input wire logic port_two_conv_b_en,
    input wire logic adc_trig_en,
    input wire logic port_three_edge_rise,
    // Interrupt masking and host reads
    input wire logic [1:0] port_int_mask,
    input wire logic serial_read_done,
    // Undervoltage lockout
    input wire logic uvlo,
    // Register commands for the converters
    input wire logic reg_conv_a_on,
    input wire logic reg_conv_b_on,
    input wire logic reg_standby,
    // Converter controls
    output logic buck_conv_a_on,
    output logic buck_conv_b_on,
    output logic buck_standby,
    // Conversion start
    output logic adc_start,
    // Host interrupt
    output logic host_int_n,
    // Status
    output logic [2:0] port_level
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] sync_a;
        logic [2:0] sync_b;
        logic [2:0] prev;
        logic [2:0] drive_low;
        logic conv_a;
        logic conv_b;
        logic standby;
        logic adc_pulse;
        logic int_n;
        logic [2:0] level;
    } pgic_top_state_t;

    pgic_top_state_t s_r;
    pgic_top_state_t s_nxt;

    // ------------------------------------------------------------
    // Edge detection and mode decode
    // ------------------------------------------------------------
    logic [2:0] rise;
    logic [2:0] fall;
    logic [1:0] sel_edge;
    logic [1:0] irq_edge;
    logic [1:0] irq_clear;
    logic [1:0] irq_req;
    logic [1:0] port_is_in;
    logic p3_trigger;
    logic port_a_cmd;
    logic port_b_cmd;
    logic port_sby_cmd;

    // Edges are taken between the second and third stage, so the first
    // stage feeds nothing but the second.
    assign rise = s_r.sync_b & ~s_r.prev;
    assign fall = ~s_r.sync_b & s_r.prev;
    assign port_is_in = ~port_dir_out[1:0];

    // ------------------------------------------------------------
    // Interrupt latches for ports one and two
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < pgic_pkg::NUM_IRQ_PORTS; g = g + 1) begin : g_irq
            // A set select bit means falling edge.
            assign sel_edge[g] = (port_lvl_sel[g] == pgic_pkg::LVL_FALL_HI) ?
                fall[g] : rise[g];
            assign irq_edge[g] = sel_edge[g] & port_int_en[g] & port_is_in[g];
            // Leaving interrupt mode releases the line as well, so a stale
            // request cannot hold it low forever.
            assign irq_clear[g] = uvlo | ~port_is_in[g] | ~port_int_en[g];

            pgic_edge_latch u_latch (
                .mclk(mclk),
                .rst_n(rst_n),
                .edge_seen(irq_edge[g]),
                .read_done(serial_read_done),
                .force_clear(irq_clear[g]),
                .irq_req(irq_req[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Port commands for the converters
    // ------------------------------------------------------------
    // A port that is not in the relevant mode votes for enable, so the register command
    // alone decides, and against standby, so standby stays off. Mode overlap is
    // not checked here; the host keeps the modes exclusive.
    always_comb begin
        port_a_cmd = 1'h1;
        port_b_cmd = 1'h1;
        port_sby_cmd = 1'h0;
        if (port_is_in[pgic_pkg::IDX_ONE] && port_one_conv_a_en) begin
            port_a_cmd = (s_r.sync_b[pgic_pkg::IDX_ONE] ==
                port_lvl_sel[pgic_pkg::IDX_ONE]);
        end
        if (port_is_in[pgic_pkg::IDX_TWO] && port_two_conv_b_en) begin
            port_b_cmd = (s_r.sync_b[pgic_pkg::IDX_TWO] ==
                port_lvl_sel[pgic_pkg::IDX_TWO]);
        end
        if (port_is_in[pgic_pkg::IDX_ONE] && port_one_standby_en) begin
            port_sby_cmd = (s_r.sync_b[pgic_pkg::IDX_ONE] ==
                port_lvl_sel[pgic_pkg::IDX_ONE]);
        end
    end

    // ------------------------------------------------------------
    // Conversion trigger on port three
    // ------------------------------------------------------------
    always_comb begin
        p3_trigger = 1'h0;
        if (port_dir_out[pgic_pkg::IDX_THREE] != pgic_pkg::DIR_OUTPUT && adc_trig_en) begin
            if (port_three_edge_rise == pgic_pkg::P3_EDGE_RISE) begin
                p3_trigger = rise[pgic_pkg::IDX_THREE];
            end else begin
                p3_trigger = fall[pgic_pkg::IDX_THREE];
            end
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.sync_a = pin_in;
        s_nxt.sync_b = s_r.sync_a;
        s_nxt.prev = s_r.sync_b;
        s_nxt.level = s_r.sync_b;
        // Open drain: a HI output releases the pin, a LO output pulls it.
        s_nxt.drive_low = port_dir_out & ~port_out_level;
        s_nxt.conv_a = reg_conv_a_on & port_a_cmd;
        s_nxt.conv_b = reg_conv_b_on & port_b_cmd;
        s_nxt.standby = reg_standby & port_sby_cmd;
        s_nxt.adc_pulse = p3_trigger;
        s_nxt.int_n = ~|(irq_req & ~port_int_mask);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Reset leaves every pin released, both converters off and standby off.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_r.sync_a <= pgic_pkg::PIN_SYNC_RST;
            s_r.sync_b <= pgic_pkg::PIN_SYNC_RST;
            s_r.prev <= pgic_pkg::PIN_SYNC_RST;
            s_r.drive_low <= pgic_pkg::PORT_IN_RST;
            s_r.conv_a <= pgic_pkg::CONV_EN_RST;
            s_r.conv_b <= pgic_pkg::CONV_EN_RST;
            s_r.standby <= pgic_pkg::STANDBY_RST;
            s_r.adc_pulse <= pgic_pkg::ADC_START_RST;
            s_r.int_n <= pgic_pkg::HOST_INT_N_RST;
            s_r.level <= pgic_pkg::PIN_SYNC_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign pin_out = {pgic_pkg::NUM_PORTS{pgic_pkg::OD_DRIVE_VALUE}};
    assign pin_oe = s_r.drive_low;
    assign buck_conv_a_on = s_r.conv_a;
    assign buck_conv_b_on = s_r.conv_b;
    assign buck_standby = s_r.standby;
    assign adc_start = s_r.adc_pulse;
    assign host_int_n = s_r.int_n;
    assign port_level = s_r.level;

endmodule

/* verification/pgic_pin_model.sv */
// External logic on the three open-drain port pins, with pull-ups.
// Assumes the bench sets each outside driver to released (1) or low (0).
`timescale 1ns/100ps
module pgic_pin_model (
    // Outside drivers
    input wire logic [2:0] ext_lvl,
    // Block side
    input wire logic [2:0] pin_oe,
    output logic [2:0] pin_in
);
    // A released wire reads the pull-up, so a stale level is never seen.
    assign pin_in = ext_lvl & ~pin_oe;
endmodule

/* verification/pgic_top_chk.sv */
// Assertions on the port block, seeing only its top ports.
// Assumes one clock and binds itself to every instance of the top.
`timescale 1ns/100ps
module pgic_top_chk (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Watched inputs
    input wire logic [2:0] port_dir_out,
    input wire logic [2:0] port_out_level,
    input wire logic [1:0] port_int_en,
    input wire logic [1:0] port_int_mask,
    input wire logic port_one_conv_a_en,
    input wire logic adc_trig_en,
    input wire logic serial_read_done,
    input wire logic uvlo,
    input wire logic reg_conv_a_on,
    input wire logic reg_conv_b_on,
    input wire logic reg_standby,
    // Watched outputs
    input wire logic [2:0] pin_out,
    input wire logic [2:0] pin_oe,
    input wire logic buck_conv_a_on,
    input wire logic buck_conv_b_on,
    input wire logic buck_standby,
    input wire logic adc_start,
    input wire logic host_int_n
);
    // ------------------------------------------------------------
    // Release causes of the interrupt line
    // ------------------------------------------------------------
    logic [1:0] act_r;
    logic [1:0] act_now;
    logic clr_cause;
    assign act_now = port_int_en & ~port_dir_out[1:0];
    // A port leaving interrupt mode counts, since that also empties its latch.
    assign clr_cause = serial_read_done | uvlo | (|(act_r & ~act_now));
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) act_r <= 2'h0;
        else act_r <= act_now;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence adc_pulse_s;
        adc_start ##1 !adc_start;
    endsequence
    open_drain_a: assert property (pin_out == 3'h0)
        else $error("pin_out not zero");
    pin_drive_a: assert property (
        $past(rst_n) |-> pin_oe == $past(port_dir_out & ~port_out_level))
        else $error("pin_oe wrong");
    conv_a_veto_a: assert property (!$past(reg_conv_a_on) |-> !buck_conv_a_on)
        else $error("conv a on against register");
    conv_b_veto_a: assert property (!$past(reg_conv_b_on) |-> !buck_conv_b_on)
        else $error("conv b on against register");
    standby_veto_a: assert property (!$past(reg_standby) |-> !buck_standby)
        else $error("standby against register");
    conv_a_free_a: assert property (
        $past(rst_n & reg_conv_a_on & ~port_one_conv_a_en) |-> buck_conv_a_on)
        else $error("conv a off without cause");
    // The line follows the mask of the cycle before, so the mask is taken one cycle back.
    int_release_a: assert property (
        $rose(host_int_n) |-> $past(clr_cause) || $past(clr_cause, 2) || (|$past(port_int_mask)))
        else $error("interrupt released without cause");
    int_source_a: assert property (
        !host_int_n |-> |($past(act_now, 2) & ~$past(port_int_mask)))
        else $error("interrupt low without unmasked port");
    adc_once_a: assert property (
        adc_start |-> $past(adc_trig_en & ~port_dir_out[2]) ##0 adc_pulse_s)
        else $error("conversion start wrong");
endmodule
bind pgic_top pgic_top_chk chk_u (.*);

/* verification/tb.sv */
// Self-checking bench for the port block with outside pin drivers.
// Assumes the checker binds itself; pins idle released (high).
`timescale 1ns/100ps
module tb;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    logic mclk = 1'h0;
    logic rst_n = 1'h0;
    logic [2:0] pin_in, pin_out, pin_oe, port_dir_out, port_out_level, port_level, ext_lvl;
    logic [1:0] port_lvl_sel, port_int_en, port_int_mask;
    logic port_one_conv_a_en, port_one_standby_en, port_two_conv_b_en, adc_trig_en, uvlo;
    logic port_three_edge_rise, serial_read_done, reg_conv_a_on, reg_conv_b_on, reg_standby;
    logic buck_conv_a_on, buck_conv_b_on, buck_standby, adc_start, host_int_n;
    int failures = 0;
    int comparisons = 0;
    int adc_cnt = 0;
    int adc_base = 0;
    // Three bits each, high to low: commands a, b, standby; modes a, standby, b;
    // level select, pin one, pin two; expected a, b, standby.
    logic [11:0] rows [7] = '{12'he1e, 12'h57a, 12'hd60, 12'hd46, 12'habd, 12'ha9c, 12'h0b8};
    always #2 mclk = ~mclk;
    always @(posedge mclk) if (adc_start === 1'h1) adc_cnt++;
    pgic_top dut_u (.*);
    pgic_pin_model pins_u (.*);
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic chk(input string what, input logic [2:0] exp, input logic [2:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict();
        if (failures == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // A bounded wait; running out of it ends the run.
    task automatic wait_int(input logic v);
        // Step off the edge first, so the line is never read as it changes.
        #1;
        for (int i = 0; i < 12 && host_int_n !== v; i++) tick(1);
        chk("host_int_n", {2'h0, v}, {2'h0, host_int_n});
        if (host_int_n !== v) give_verdict();
    endtask
    task automatic drive(input logic [2:0] v);
        @(posedge mclk) ext_lvl <= v;
        tick(3);
    endtask
    task automatic read_pulse();
        @(posedge mclk) serial_read_done <= 1'h1;
        @(posedge mclk) serial_read_done <= 1'h0;
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {port_dir_out, port_out_level, port_lvl_sel, port_int_en, port_int_mask, uvlo} = '0;
        {port_one_conv_a_en, port_one_standby_en, port_two_conv_b_en, adc_trig_en} = '0;
        {port_three_edge_rise, serial_read_done, reg_conv_a_on, reg_conv_b_on, reg_standby} = '0;
        ext_lvl = 3'h7;
        repeat (3) @(posedge mclk);
        rst_n <= 1'h1;
        tick(4);
        chk("reset outputs", 3'h4, {host_int_n, buck_conv_a_on, buck_standby});
        chk("reset pin_oe", 3'h0, pin_oe);
        chk("port_level", 3'h7, port_level);
        // Port one never holds two input modes at once.
        foreach (rows[i]) begin
            @(posedge mclk);
            {reg_conv_a_on, reg_conv_b_on, reg_standby} <= rows[i][11:9];
            {port_one_conv_a_en, port_one_standby_en, port_two_conv_b_en} <= rows[i][8:6];
            port_lvl_sel <= {2{rows[i][5]}};
            ext_lvl <= {1'h1, rows[i][3], rows[i][4]};
            tick(6);
            chk("converters", rows[i][2:0],
                {buck_conv_a_on, buck_conv_b_on, buck_standby});
        end
        @(posedge mclk);
        {port_one_conv_a_en, port_one_standby_en, port_two_conv_b_en} <= 3'h0;
        {ext_lvl, port_dir_out, port_out_level} <= {3'h7, 3'h7, 3'h2};
        tick(6);
        chk("pin_oe", 3'h5, pin_oe);
        chk("port_level", 3'h2, port_level);
        @(posedge mclk) {port_dir_out, port_lvl_sel, port_int_en} <= {3'h0, 2'h1, 2'h1};
        tick(3);
        drive(3'h6);
        wait_int(1'h0);
        read_pulse();
        tick(5);
        chk("lone edge read", 3'h0, {2'h0, host_int_n});
        drive(3'h7);
        drive(3'h6);
        read_pulse();
        wait_int(1'h1);
        drive(3'h7);
        drive(3'h6);
        wait_int(1'h0);
        drive(3'h7);
        drive(3'h6);
        drive(3'h7);
        drive(3'h6);
        chk("no toggling", 3'h0, {2'h0, host_int_n});
        @(posedge mclk) uvlo <= 1'h1;
        @(posedge mclk) uvlo <= 1'h0;
        wait_int(1'h1);
        drive(3'h7);
        drive(3'h6);
        wait_int(1'h0);
        @(posedge mclk) port_dir_out <= 3'h1;
        wait_int(1'h1);
        @(posedge mclk) {port_dir_out, port_lvl_sel, port_int_en, port_int_mask} <= 9'h0a;
        drive(3'h7);
        drive(3'h5);
        drive(3'h7);
        tick(3);
        chk("masked request", 3'h1, {2'h0, host_int_n});
        @(posedge mclk) port_int_mask <= 2'h0;
        wait_int(1'h0);
        @(posedge mclk) {port_int_en, adc_trig_en, port_three_edge_rise} <= 4'h3;
        wait_int(1'h1);
        // The pulse lands three edges after the pin moves and is counted one edge later.
        adc_base = adc_cnt;
        drive(3'h3);
        drive(3'h7);
        tick(2);
        chk("rising trigger", 3'h1, 3'(adc_cnt - adc_base));
        @(posedge mclk) port_three_edge_rise <= 1'h0;
        drive(3'h3);
        drive(3'h7);
        tick(2);
        chk("falling trigger", 3'h2, 3'(adc_cnt - adc_base));
        give_verdict();
    end
    initial begin
        #100000;
        failures++;
        give_verdict();
    end
endmodule
